// ==== hdl/ocs_clock_switch.sv ====
// Internal oscillator control and run-time system clock switch
// Summary of operation
// RULE1: Reset starts fast oscillator at 1 MHz for code 110, 64 MHz for 000.
// RULE2: Divider field divides fast oscillator from 1:1 up to 1:512.
// RULE3: Mid clocks 500 kHz and 31.25 kHz stay constant for every fast setting.
// RULE4: Mid clocks are never a system clock source, only peripheral feeds.
// RULE5: Trim is 6-bit two's complement, resets 00h, 1Fh max, 20h min.
// RULE6: Trim change shifts frequency while running; no completion flag.
// RULE7: Trim never affects the 31 kHz slow oscillator.
// RULE8: ADC RC oscillator at 600 kHz on when forced or chosen by ADC.
// RULE9: Status shows ready per oscillator; all but PLL manually enableable.
// RULE10: New fast frequency clears fast/mid ready until settled; mid clock stalls.
// RULE11: Switch permit clear blocks request writes; set lets them start a switch.
// RULE12: Old clock runs until new source ready; divider-only is ready at once.
// RULE13: New source ready sets ready bit and switch flag together, irq if enabled.
// RULE14: Switch interrupt never wakes from Sleep.
// RULE15: Hold clear completes switch when new source ready sets.
// RULE16: Hold set defers switch; software clears hold or copies current to abandon.
// RULE17: Under Doze a pending switch occurs on the next clock cycle.
// RULE18: Current register holds old selection until switch; then done set, ready cleared.
// RULE19: PLL input change runs on old, then halts system while PLL relocks.
// RULE20: Sleep before completion drops the switch.
// RULE21: Wake with hold clear resumes new clock and sets flag; else re-requests.
// RULE22: Switch flag stays set until software clears it.
// RULE23: Source code 010 selects external oscillator with 4x PLL.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ocs_clock_switch #(
  parameter int SETTLE_CYCLES = ocs_pkg::SETTLE_CYC,
  parameter int RELOCK_CYCLES = ocs_pkg::RELOCK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  reset_source_select,
  input  wire logic        switch_permit,
  input  wire logic        ext_osc_ready_in,
  input  wire logic        adc_selects_rc,
  input  wire logic        doze_active,
  output logic [2:0]       sys_source,
  output logic [3:0]       sys_divider,
  output logic [3:0]       fast_freq_out,
  output logic [5:0]       fast_trim_out,
  output logic             adc_rc_osc_on,
  output logic             mid_clk_500k,
  output logic             mid_clk_31k,
  output logic             sys_clk_halt,
  output logic             switch_irq
);
  logic        acc;
  logic        wr;
  logic [2:0]  new_src_q;
  logic [3:0]  new_div_q;
  logic [2:0]  cur_src_q;
  logic [3:0]  cur_div_q;
  logic        hold_q;
  logic        done_q;
  logic        nrdy_q;
  logic        flag_q;
  logic        irq_en_q;
  logic [7:0]  trim_q;
  logic [3:0]  freq_q;
  logic [7:0]  en_q;
  logic        fast_rdy_q;
  logic [15:0] settle_q;
  logic        ext_s1_q;
  logic        ext_s2_q;
  logic        adc_s1_q;
  logic        adc_s2_q;
  logic        doze_s1_q;
  logic        doze_s2_q;
  logic        sleep_q;
  logic        strapped_q;
  logic [15:0] relock_q;
  logic [15:0] mid_cnt_q;
  logic [5:0]  mid_lo_cnt_q;
  ocs_pkg::ocs_sw_e sw_q;
  logic        req_ready;
  logic        pll_input_change;
  logic        sleep_ev;
  logic        wake_ev;
  logic        pending;

  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign sleep_ev = wr && paddr == ocs_pkg::ADDR_EVENT && pwdata[ocs_pkg::EV_SLEEP];
  assign wake_ev  = wr && paddr == ocs_pkg::ADDR_EVENT && pwdata[ocs_pkg::EV_WAKE];
  assign pending  = (new_src_q != cur_src_q) || (new_div_q != cur_div_q);

  // Ready of a source code; mid clocks have no code, so never selectable
  function automatic logic src_ready(input logic [2:0] s, input logic fr, input logic ex);
    if (s == ocs_pkg::SRC_FAST || s == ocs_pkg::SRC_FAST64) begin
      src_ready = fr;
    end else begin
      src_ready = ex;
    end
  endfunction

  // Mid clock half period in fast-clock cycles for a given frequency code
  // Codes past the top rate clamp to it, so the divider never overflows
  function automatic logic [15:0] mid_half(input logic [3:0] f);
    int idx;
    idx = (f > ocs_pkg::FREQ_64MHZ) ? int'(ocs_pkg::FREQ_64MHZ) : int'(f);
    mid_half = 16'((ocs_pkg::FAST_BASE_KHZ * ocs_pkg::FAST_MHZ[idx]) /
                   (2 * ocs_pkg::MID_HI_KHZ));
  endfunction

  assign req_ready = (new_src_q == cur_src_q) ||
                     src_ready(new_src_q, fast_rdy_q, ext_s2_q); // see RULE12
  assign pll_input_change = new_src_q == ocs_pkg::SRC_EXTPLL &&
                            cur_src_q == ocs_pkg::SRC_EXTPLL && new_div_q != cur_div_q;

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q  <= 1'b0;
      ext_s2_q  <= 1'b0;
      adc_s1_q  <= 1'b0;
      adc_s2_q  <= 1'b0;
      doze_s1_q <= 1'b0;
      doze_s2_q <= 1'b0;
    end else begin
      ext_s1_q  <= ext_osc_ready_in;
      ext_s2_q  <= ext_s1_q;
      adc_s1_q  <= adc_selects_rc;
      adc_s2_q  <= adc_s1_q;
      doze_s1_q <= doze_active;
      doze_s2_q <= doze_s1_q;
    end
  end

  // Request fields, strap caught after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_src_q  <= ocs_pkg::SRC_FAST1;
      new_div_q  <= 4'h0;
      strapped_q <= 1'b0;
      freq_q     <= ocs_pkg::FREQ_1MHZ;
    end else if (!strapped_q) begin
      strapped_q <= 1'b1;
      new_src_q  <= reset_source_select;
      freq_q     <= (reset_source_select == ocs_pkg::SRC_FAST64) ?
                    ocs_pkg::FREQ_64MHZ : ocs_pkg::FREQ_1MHZ; // see RULE1
    end else if (wr && paddr == ocs_pkg::ADDR_REQUEST && switch_permit) begin
      new_src_q <= pwdata[ocs_pkg::SRC_LSB +: 3]; // see RULE11 RULE23 RULE16
      new_div_q <= pwdata[ocs_pkg::DIV_LSB +: 4]; // see RULE2
    end else if (wr && paddr == ocs_pkg::ADDR_FREQ) begin
      freq_q <= pwdata[3:0];
    end
  end

  // Plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q   <= 1'b0;
      irq_en_q <= 1'b0;
      trim_q   <= ocs_pkg::TRIM_RESET;
      en_q     <= 8'h00;
    end else if (wr) begin
      if (paddr == ocs_pkg::ADDR_CTRL) hold_q <= pwdata[ocs_pkg::CTRL_HOLD];
      if (paddr == ocs_pkg::ADDR_IRQ) irq_en_q <= pwdata[ocs_pkg::IRQ_EN];
      if (paddr == ocs_pkg::ADDR_TRIM) trim_q <= {2'b00, pwdata[5:0] & ocs_pkg::TRIM_MASK}; // see RULE5
      if (paddr == ocs_pkg::ADDR_ENABLE) en_q <= pwdata[7:0] & ocs_pkg::EN_MASK; // see RULE9
    end
  end

  // Fast oscillator settle after frequency change; trim needs no settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_rdy_q <= 1'b0;
      settle_q   <= 16'h0000;
    end else if (wr && paddr == ocs_pkg::ADDR_FREQ) begin
      fast_rdy_q <= 1'b0; // see RULE10
      settle_q   <= 16'(SETTLE_CYCLES);
    end else if (settle_q > 16'h0001) begin
      settle_q <= settle_q - 16'h0001;
    end else begin
      settle_q   <= 16'h0000;
      fast_rdy_q <= 1'b1;
    end
  end

  // Mid clocks: divider reloaded per frequency code, frozen while not ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mid_cnt_q    <= 16'h0000;
      mid_lo_cnt_q <= 6'h00;
      mid_clk_500k <= 1'b0;
      mid_clk_31k  <= 1'b0;
    end else if (fast_rdy_q) begin // see RULE10
      if (mid_cnt_q + 16'h0001 >= mid_half(freq_q)) begin // see RULE3
        mid_cnt_q    <= 16'h0000;
        mid_clk_500k <= ~mid_clk_500k;
        mid_lo_cnt_q <= mid_lo_cnt_q + 6'h01;
        if (mid_lo_cnt_q[3:0] == 4'hf) mid_clk_31k <= ~mid_clk_31k; // see RULE3
      end else begin
        mid_cnt_q <= mid_cnt_q + 16'h0001;
      end
    end
  end

  // Switch sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q      <= ocs_pkg::SW_IDLE;
      cur_src_q <= ocs_pkg::SRC_FAST1;
      cur_div_q <= 4'h0;
      nrdy_q    <= 1'b0;
      done_q    <= 1'b1;
      relock_q  <= 16'h0000;
      sleep_q   <= 1'b0;
      flag_q    <= 1'b0;
    end else begin
      if (wr && paddr == ocs_pkg::ADDR_IRQ && !pwdata[ocs_pkg::IRQ_FLAG]) flag_q <= 1'b0; // see RULE22
      if (sleep_ev) begin
        sleep_q <= 1'b1;
        sw_q    <= ocs_pkg::SW_IDLE; // see RULE20
        nrdy_q  <= 1'b0;
      end else if (sleep_q) begin
        if (wake_ev) begin // see RULE14
          sleep_q <= 1'b0;
          if (pending && !hold_q) begin // see RULE21
            cur_src_q <= new_src_q;
            cur_div_q <= new_div_q;
            done_q    <= 1'b1;
            flag_q    <= 1'b1;
          end
        end
      end else begin
        unique case (sw_q)
          ocs_pkg::SW_IDLE: begin
            if (!strapped_q) begin
              cur_src_q <= reset_source_select; // see RULE1
            end else if (pending) begin
              done_q <= 1'b0;
              sw_q   <= ocs_pkg::SW_WAIT;
            end
          end
          ocs_pkg::SW_WAIT: begin
            if (!pending) begin
              sw_q   <= ocs_pkg::SW_IDLE; // see RULE16
              done_q <= 1'b1;
              nrdy_q <= 1'b0;
            end else if (req_ready) begin
              if (!nrdy_q) flag_q <= 1'b1; // see RULE13
              nrdy_q <= 1'b1;
              if (!hold_q) begin // see RULE15 RULE17
                if (pll_input_change) begin
                  relock_q <= 16'(RELOCK_CYCLES);
                  sw_q     <= ocs_pkg::SW_RELOCK; // see RULE19
                end else begin
                  cur_src_q <= new_src_q; // see RULE18
                  cur_div_q <= new_div_q;
                  done_q    <= 1'b1;
                  nrdy_q    <= 1'b0;
                  sw_q      <= ocs_pkg::SW_IDLE;
                end
              end
            end
          end
          ocs_pkg::SW_RELOCK: begin
            if (relock_q > 16'h0001) begin
              relock_q <= relock_q - 16'h0001;
            end else begin
              relock_q  <= 16'h0000;
              cur_src_q <= new_src_q;
              cur_div_q <= new_div_q;
              done_q    <= 1'b1;
              nrdy_q    <= 1'b0;
              sw_q      <= ocs_pkg::SW_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Outputs; doze input only observed, switch never waits for CPU cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_source    <= ocs_pkg::SRC_FAST1;
      sys_divider   <= 4'h0;
      fast_freq_out <= ocs_pkg::FREQ_1MHZ;
      fast_trim_out <= 6'h00;
      adc_rc_osc_on <= 1'b0;
      sys_clk_halt  <= 1'b0;
      switch_irq    <= 1'b0;
    end else begin
      sys_source    <= cur_src_q; // see RULE4
      sys_divider   <= cur_div_q;
      fast_freq_out <= freq_q;
      fast_trim_out <= trim_q[5:0]; // see RULE6 RULE7
      adc_rc_osc_on <= en_q[ocs_pkg::EN_ADC] || adc_s2_q; // see RULE8
      sys_clk_halt  <= (sw_q == ocs_pkg::SW_RELOCK) || sleep_q;
      switch_irq    <= flag_q && irq_en_q && !sleep_q; // see RULE14
    end
  end

  // APB slave, zero wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ocs_pkg::ADDR_REQUEST: prdata <= {25'h0, new_src_q, new_div_q};
          ocs_pkg::ADDR_CURRENT: prdata <= {25'h0, cur_src_q, cur_div_q};
          ocs_pkg::ADDR_CTRL:    prdata <= {24'h0, hold_q, 2'b00, done_q, nrdy_q, 3'b000};
          ocs_pkg::ADDR_STATUS:  prdata <= {24'h0, ext_s2_q, fast_rdy_q, fast_rdy_q, 1'b1,
                                            1'b0, adc_rc_osc_on, 1'b0, ext_s2_q}; // see RULE9
          ocs_pkg::ADDR_TRIM:    prdata <= {24'h0, trim_q};
          ocs_pkg::ADDR_FREQ:    prdata <= {28'h0, freq_q};
          ocs_pkg::ADDR_ENABLE:  prdata <= {24'h0, en_q};
          ocs_pkg::ADDR_IRQ:     prdata <= {30'h0, irq_en_q, flag_q};
          default:               prdata <= 32'h0000_0000;
        endcase
        if (paddr > ocs_pkg::ADDR_EVENT || paddr[1:0] != 2'b00) pslverr <= 1'b0;
      end
    end
  end

  sequence s_ready_seen;
    sw_q == ocs_pkg::SW_WAIT && req_ready && !hold_q && !pll_input_change && !sleep_ev;
  endsequence

  a_switch_completes: assert property (@(posedge pclk) disable iff (!presetn) // see RULE15
    s_ready_seen |=> cur_src_q == $past(new_src_q) && done_q)
    else $error("switch did not complete");
  a_doze_switches: assert property (@(posedge pclk) disable iff (!presetn) // see RULE17
    doze_s2_q ##0 s_ready_seen |=> cur_div_q == $past(new_div_q))
    else $error("switch waited under doze");
  a_hold_defers: assert property (@(posedge pclk) disable iff (!presetn) // see RULE16
    sw_q == ocs_pkg::SW_WAIT && hold_q && !sleep_ev |=> $stable(cur_src_q))
    else $error("switch taken under hold");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // see RULE22
    flag_q && !(wr && paddr == ocs_pkg::ADDR_IRQ) |=> flag_q)
    else $error("flag cleared by hardware");
  a_freq_clears_ready: assert property (@(posedge pclk) disable iff (!presetn) // see RULE10
    wr && paddr == ocs_pkg::ADDR_FREQ |=> !fast_rdy_q)
    else $error("ready not cleared");
  a_mid_stalls: assert property (@(posedge pclk) disable iff (!presetn) // see RULE10
    !fast_rdy_q |=> $stable(mid_clk_500k))
    else $error("mid clock ran while not ready");
  a_permit_blocks: assert property (@(posedge pclk) disable iff (!presetn) // see RULE11
    strapped_q && !switch_permit |=> $stable(new_src_q))
    else $error("request taken without permit");
  a_sleep_drops: assert property (@(posedge pclk) disable iff (!presetn) // see RULE20
    sleep_ev |=> sw_q == ocs_pkg::SW_IDLE && !nrdy_q)
    else $error("switch kept across sleep");
  a_no_irq_sleep: assert property (@(posedge pclk) disable iff (!presetn) // see RULE14
    sleep_q |=> !switch_irq)
    else $error("irq during sleep");
  a_trim_reset: assert property (@(posedge pclk) disable iff (!presetn) // see RULE5
    !strapped_q |-> trim_q == ocs_pkg::TRIM_RESET)
    else $error("trim not reset");
  a_adc_on: assert property (@(posedge pclk) disable iff (!presetn) // see RULE8
    adc_s2_q |=> adc_rc_osc_on)
    else $error("adc rc not on");
  a_relock_halts: assert property (@(posedge pclk) disable iff (!presetn) // see RULE19
    sw_q == ocs_pkg::SW_RELOCK |=> sys_clk_halt)
    else $error("no halt while relock");
endmodule
`default_nettype wire

// ==== hdl/ocs_pkg.sv ====
// Package: register map, field layouts and timing for the clock switch block
package ocs_pkg;
  localparam logic [11:0] ADDR_REQUEST = 12'h000;
  localparam logic [11:0] ADDR_CURRENT = 12'h004;
  localparam logic [11:0] ADDR_CTRL    = 12'h008;
  localparam logic [11:0] ADDR_STATUS  = 12'h00c;
  localparam logic [11:0] ADDR_TRIM    = 12'h010;
  localparam logic [11:0] ADDR_FREQ    = 12'h014;
  localparam logic [11:0] ADDR_ENABLE  = 12'h018;
  localparam logic [11:0] ADDR_IRQ     = 12'h01c;
  localparam logic [11:0] ADDR_EVENT   = 12'h020;
  // Request/current layout
  localparam int DIV_LSB = 0;
  localparam int SRC_LSB = 4;
  // Control bits
  localparam int CTRL_HOLD = 7;
  localparam int CTRL_DONE = 4;
  localparam int CTRL_NRDY = 3;
  // Status bits
  localparam int ST_EXT  = 7;
  localparam int ST_FAST = 6;
  localparam int ST_MID  = 5;
  localparam int ST_SLOW = 4;
  localparam int ST_SEC  = 3;
  localparam int ST_ADC  = 2;
  localparam int ST_PLL  = 0;
  // Manual enable bits
  localparam int EN_ADC = 2;
  localparam int EN_FAST = 6;
  localparam int EN_MID = 5;
  // Irq register bits
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_EN   = 1;
  // Event register bits (write 1 to pulse)
  localparam int EV_SLEEP = 0;
  localparam int EV_WAKE  = 1;
  // Source and frequency codes, trim reset value and write masks
  localparam logic [2:0] SRC_FAST64 = 3'h0;
  localparam logic [2:0] SRC_EXTPLL = 3'h2;
  localparam logic [2:0] SRC_FAST1  = 3'h6;
  localparam logic [2:0] SRC_FAST   = 3'h6;
  localparam logic [3:0] FREQ_1MHZ  = 4'h0;
  localparam logic [3:0] FREQ_64MHZ = 4'h8;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [5:0] TRIM_MASK  = 6'h3f;
  localparam logic [7:0] EN_MASK    = 8'hfc;
  // Mid clock outputs as dividers of fast clock in kHz
  localparam int MID_HI_KHZ = 500;
  localparam int FAST_BASE_KHZ = 1000;
  // Fast oscillator rate in MHz for each frequency code
  localparam int FAST_MHZ [0:8] = '{1, 2, 4, 8, 12, 16, 32, 48, 64};
  // Settle and relock times in ns
  localparam int SETTLE_NS = 2000;
  localparam int RELOCK_NS = 1000;
  localparam int CLK_NS    = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RELOCK_CYC = (RELOCK_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_RELOCK} ocs_sw_e;
endpackage

// ==== tb/tb_top.sv ====
// Self-checking bench for the clock switch block over APB
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  strap = 3'h6;
  logic        permit = 1'b1;
  logic        ext_rdy = 1'b0;
  logic        adc_sel = 1'b0;
  logic        doze = 1'b0;
  logic [2:0]  sys_source;
  logic [3:0]  sys_divider;
  logic        adc_on;
  logic        irq;
  logic        halt;
  logic        mid500;
  logic        mid31;
  logic [3:0]  freq_out;
  logic [5:0]  trim_out;
  logic        rd_err;
  logic [31:0] rd;
  int          num_errors = 0;
  int          tests_run = 0;

  always #50 pclk = ~pclk;

  // Short settle counts keep the run brief
  ocs_clock_switch #(.SETTLE_CYCLES(3), .RELOCK_CYCLES(3)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_source_select(strap),
    .switch_permit(permit), .ext_osc_ready_in(ext_rdy), .adc_selects_rc(adc_sel),
    .doze_active(doze), .sys_source(sys_source), .sys_divider(sys_divider),
    .fast_freq_out(freq_out), .fast_trim_out(trim_out), .adc_rc_osc_on(adc_on),
    .mid_clk_500k(mid500), .mid_clk_31k(mid31), .sys_clk_halt(halt), .switch_irq(irq)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // Holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded poll of a register field
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, a, 32'h0);
      if ((rd & m) === e) break;
    end
  endtask

  task automatic t_reset();
    chk({29'h0, sys_source}, 32'h6, "reset source");
    apb(1'b0, ocs_pkg::ADDR_CURRENT, 32'h0);
    chk(rd, 32'h60, "current after reset");
    apb(1'b0, ocs_pkg::ADDR_TRIM, 32'h0);
    chk(rd, 32'h0, "trim reset");
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk({31'h0, rd_err}, 32'h0, "no slave error");
    $display("test reset done");
  endtask

  task automatic t_trim();
    apb(1'b1, ocs_pkg::ADDR_TRIM, 32'h1f);
    apb(1'b0, ocs_pkg::ADDR_TRIM, 32'h0);
    chk(rd, 32'h1f, "trim max");
    apb(1'b1, ocs_pkg::ADDR_TRIM, 32'h20);
    apb(1'b0, ocs_pkg::ADDR_TRIM, 32'h0);
    chk(rd, 32'h20, "trim min");
    chk({26'h0, trim_out}, 32'h20, "trim out");
    $display("test trim done");
  endtask

  // Cycles until a mid clock next changes level
  task automatic gap(input logic slow, output int n);
    logic m0;
    m0 = slow ? mid31 : mid500;
    n = 0;
    while ((slow ? mid31 : mid500) === m0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Frequency change clears ready; mid clocks keep their rate at 64 MHz
  task automatic t_freq();
    int n;
    apb(1'b1, ocs_pkg::ADDR_FREQ, {28'h0, ocs_pkg::FREQ_64MHZ});
    apb(1'b0, ocs_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h60, 32'h0, "ready cleared");
    poll(ocs_pkg::ADDR_STATUS, 32'h60, 32'h60);
    chk(rd & 32'h60, 32'h60, "ready again");
    chk({28'h0, freq_out}, {28'h0, ocs_pkg::FREQ_64MHZ}, "freq code out");
    gap(1'b0, n);
    gap(1'b0, n);
    chk(n, 32'h40, "500k half period");
    gap(1'b1, n);
    gap(1'b1, n);
    chk(n, 32'h400, "31k half period");
    $display("test freq done");
  endtask

  task automatic t_permit();
    permit <= 1'b0;
    apb(1'b1, ocs_pkg::ADDR_REQUEST, 32'h61);
    apb(1'b0, ocs_pkg::ADDR_REQUEST, 32'h0);
    chk(rd, 32'h60, "write blocked");
    permit <= 1'b1;
    $display("test permit done");
  endtask

  // Divider-only change held, then released
  task automatic t_hold();
    apb(1'b1, ocs_pkg::ADDR_CTRL, 32'h80);
    apb(1'b1, ocs_pkg::ADDR_IRQ, 32'h2);
    apb(1'b1, ocs_pkg::ADDR_REQUEST, 32'h63);
    poll(ocs_pkg::ADDR_CTRL, 32'h08, 32'h08);
    chk(rd & 32'h08, 32'h08, "new ready set");
    apb(1'b0, ocs_pkg::ADDR_IRQ, 32'h0);
    chk(rd & 32'h1, 32'h1, "flag with ready");
    apb(1'b0, ocs_pkg::ADDR_CURRENT, 32'h0);
    chk(rd, 32'h60, "held on old");
    chk({28'h0, sys_divider}, 32'h0, "old divider out");
    apb(1'b1, ocs_pkg::ADDR_CTRL, 32'h00);
    poll(ocs_pkg::ADDR_CURRENT, 32'h7f, 32'h63);
    chk(rd, 32'h63, "switched");
    apb(1'b0, ocs_pkg::ADDR_CTRL, 32'h0);
    chk(rd & 32'h18, 32'h10, "done set ready clear");
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b0, ocs_pkg::ADDR_IRQ, 32'h0);
    chk(rd & 32'h1, 32'h1, "flag sticky");
    apb(1'b1, ocs_pkg::ADDR_IRQ, 32'h2);
    apb(1'b0, ocs_pkg::ADDR_IRQ, 32'h0);
    chk(rd & 32'h1, 32'h0, "flag cleared");
    $display("test hold done");
  endtask

  // PLL request dropped by sleep, completed on wake
  task automatic t_sleep();
    ext_rdy <= 1'b0;
    apb(1'b1, ocs_pkg::ADDR_REQUEST, 32'h23);
    apb(1'b1, ocs_pkg::ADDR_EVENT, 32'h1);
    ext_rdy <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({29'h0, sys_source}, 32'h6, "no switch in sleep");
    chk({31'h0, irq}, 32'h0, "no irq in sleep");
    apb(1'b1, ocs_pkg::ADDR_EVENT, 32'h2);
    poll(ocs_pkg::ADDR_CURRENT, 32'h7f, 32'h23);
    chk(rd, 32'h23, "new clock on wake");
    apb(1'b0, ocs_pkg::ADDR_IRQ, 32'h0);
    chk(rd & 32'h1, 32'h1, "flag on wake");
    chk({31'h0, irq}, 32'h1, "irq after wake");
    apb(1'b1, ocs_pkg::ADDR_EVENT, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq masked in sleep");
    apb(1'b1, ocs_pkg::ADDR_EVENT, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "irq back after wake");
    $display("test sleep done");
  endtask

  // PLL input change halts the system while the PLL relocks
  task automatic t_relock();
    apb(1'b1, ocs_pkg::ADDR_REQUEST, 32'h21);
    repeat (4) @(posedge pclk);
    chk({31'h0, halt}, 32'h1, "halt while relocking");
    chk({28'h0, sys_divider}, 32'h3, "old input kept");
    poll(ocs_pkg::ADDR_CURRENT, 32'h7f, 32'h21);
    chk(rd, 32'h21, "new input after relock");
    chk({31'h0, halt}, 32'h0, "halt released");
    $display("test relock done");
  endtask

  // Sleep under hold: old clock kept, request raised again on wake
  task automatic t_wake_hold();
    apb(1'b1, ocs_pkg::ADDR_CTRL, 32'h80);
    apb(1'b1, ocs_pkg::ADDR_REQUEST, 32'h60);
    poll(ocs_pkg::ADDR_CTRL, 32'h08, 32'h08);
    apb(1'b1, ocs_pkg::ADDR_EVENT, 32'h1);
    apb(1'b0, ocs_pkg::ADDR_CTRL, 32'h0);
    chk(rd & 32'h08, 32'h0, "ready dropped in sleep");
    apb(1'b1, ocs_pkg::ADDR_EVENT, 32'h2);
    poll(ocs_pkg::ADDR_CTRL, 32'h08, 32'h08);
    chk(rd & 32'h08, 32'h08, "new source asked again");
    apb(1'b0, ocs_pkg::ADDR_CURRENT, 32'h0);
    chk(rd, 32'h21, "old clock after wake");
    doze <= 1'b1;
    apb(1'b1, ocs_pkg::ADDR_CTRL, 32'h00);
    poll(ocs_pkg::ADDR_CURRENT, 32'h7f, 32'h60);
    chk(rd, 32'h60, "switch under doze");
    doze <= 1'b0;
    $display("test wake hold done");
  endtask

  // Mid-run reset with the 64 MHz strap
  task automatic t_strap();
    presetn <= 1'b0;
    strap <= 3'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({29'h0, sys_source}, 32'h0, "strap 000 source");
    apb(1'b0, ocs_pkg::ADDR_FREQ, 32'h0);
    chk(rd, {28'h0, ocs_pkg::FREQ_64MHZ}, "strap 000 at 64 MHz");
    $display("test strap done");
  endtask

  task automatic t_adc();
    adc_sel <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({31'h0, adc_on}, 32'h1, "adc osc auto on");
    adc_sel <= 1'b0;
    apb(1'b1, ocs_pkg::ADDR_ENABLE, 32'h4);
    repeat (6) @(posedge pclk);
    chk({31'h0, adc_on}, 32'h1, "adc osc forced");
    apb(1'b1, ocs_pkg::ADDR_ENABLE, 32'h0);
    repeat (6) @(posedge pclk);
    chk({31'h0, adc_on}, 32'h0, "adc osc off");
    $display("test adc done");
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_trim();
    t_freq();
    t_permit();
    t_hold();
    t_sleep();
    t_relock();
    t_wake_hold();
    t_adc();
    t_strap();
    complete_run();
  end

  // Whole sequence needs well under five thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
